// ===== inc/srfi_params.svh
`ifndef SRFI_PARAMS_SVH
`define SRFI_PARAMS_SVH
// Clock rate in Hz
`define SRFI_CLK_HZ 50000000
// Times in ms as printed (test pulse in us), with the macro that turns ms into cycle counts
`define SRFI_SUPPLY_LOSS_MS 20
`define SRFI_POWER_OFF_MS 1000
`define SRFI_DIGIT_FLASH_MS 1000
`define SRFI_SHORT_FLASH_MS 150
`define SRFI_OPEN_PAUSE_MS 2000
`define SRFI_DIGIT_PAUSE_MS 2000
`define SRFI_BLINK_HALF_MS 250
`define SRFI_INIT_MS 500
`define SRFI_TEST_PERIOD_MS 100
`define SRFI_TEST_PULSE_US 400
`define SRFI_MS_TO_CYC(ms) ((ms) * (`SRFI_CLK_HZ / 1000))
`define SRFI_SHORT_FLASHES 3
`define SRFI_MAX_DIGITS 4
`define SRFI_ZERO_FLASHES 16
// Codes for supply loss and mode change
`define SRFI_CODE_SUPPLY 16'h0082
`define SRFI_CODE_MODE 16'h0003
`endif

// ===== inc/srfi_pkg.sv
package srfi_pkg;
  typedef enum logic [4:0] {
    SRFI_INIT = 5'h01,
    SRFI_WAIT_START = 5'h02,
    SRFI_RUN = 5'h04,
    SRFI_BAD_MODE = 5'h08,
    SRFI_FAULT = 5'h10
  } srfi_state_t;
  typedef enum logic [5:0] {
    SRFI_FC_SHORT_ON = 6'h01,
    SRFI_FC_SHORT_OFF = 6'h02,
    SRFI_FC_PAUSE = 6'h04,
    SRFI_FC_LONG_ON = 6'h08,
    SRFI_FC_LONG_OFF = 6'h10,
    SRFI_FC_IDLE = 6'h20
  } srfi_fc_state_t;
endpackage : srfi_pkg

// ===== design/srfi_flash_code.sv
`timescale 1ns/1ps
`default_nettype none
`include "srfi_params.svh"
module srfi_flash_code #(
  parameter int SHORT_CYC = `SRFI_MS_TO_CYC(`SRFI_SHORT_FLASH_MS),
  parameter int PAUSE_CYC = `SRFI_MS_TO_CYC(`SRFI_OPEN_PAUSE_MS),
  parameter int GAP_CYC = `SRFI_MS_TO_CYC(`SRFI_DIGIT_PAUSE_MS),
  parameter int LONG_CYC = `SRFI_MS_TO_CYC(`SRFI_DIGIT_FLASH_MS)
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [15:0] code_in,
  output logic led_out
);
  initial begin
    if (SHORT_CYC < 1 || PAUSE_CYC < 1 || GAP_CYC < 1 || LONG_CYC <= SHORT_CYC) begin
      $error("srfi_flash_code: bad timing");
    end
  end
  // ****************************************
  // Sequencer
  // ****************************************
  srfi_pkg::srfi_fc_state_t st_reg;
  logic [31:0] tmr_reg;
  logic [4:0] cnt_reg;
  logic [1:0] dig_reg;
  logic [1:0] ndig;
  logic [3:0] cur_dig;
  logic [4:0] flashes;
  always_comb begin
    ndig = 2'h0;
    if (code_in[15:12] != 4'h0) ndig = 2'h3;
    else if (code_in[11:8] != 4'h0) ndig = 2'h2;
    else if (code_in[7:4] != 4'h0) ndig = 2'h1;
    cur_dig = code_in[{dig_reg, 2'b00} +: 4];
    flashes = (cur_dig == 4'h0) ? 5'(`SRFI_ZERO_FLASHES) : {1'b0, cur_dig};
  end
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= srfi_pkg::SRFI_FC_IDLE;
      tmr_reg <= 32'h0;
      cnt_reg <= 5'h0;
      dig_reg <= 2'h0;
      led_out <= 1'b0;
    end else if (!run_in) begin
      st_reg <= srfi_pkg::SRFI_FC_IDLE;
      led_out <= 1'b0;
      // Drop a part-run count so the next frame opens at once
      tmr_reg <= 32'h0;
    end else if (tmr_reg != 32'h0) begin
      tmr_reg <= tmr_reg - 32'h1;
    end else begin
      case (st_reg)
        srfi_pkg::SRFI_FC_IDLE: begin
          st_reg <= srfi_pkg::SRFI_FC_SHORT_ON;
          led_out <= 1'b1;
          cnt_reg <= 5'h0;
          dig_reg <= ndig;
          tmr_reg <= 32'(SHORT_CYC - 1);
        end
        srfi_pkg::SRFI_FC_SHORT_ON: begin
          st_reg <= srfi_pkg::SRFI_FC_SHORT_OFF;
          led_out <= 1'b0;
          tmr_reg <= 32'(SHORT_CYC - 1);
        end
        srfi_pkg::SRFI_FC_SHORT_OFF: begin
          if (cnt_reg == 5'(`SRFI_SHORT_FLASHES - 1)) begin
            st_reg <= srfi_pkg::SRFI_FC_PAUSE;
            tmr_reg <= 32'(PAUSE_CYC - 1);
            cnt_reg <= 5'h0;
          end else begin
            st_reg <= srfi_pkg::SRFI_FC_SHORT_ON;
            led_out <= 1'b1;
            cnt_reg <= cnt_reg + 5'h1;
            tmr_reg <= 32'(SHORT_CYC - 1);
          end
        end
        srfi_pkg::SRFI_FC_PAUSE: begin
          st_reg <= srfi_pkg::SRFI_FC_LONG_ON;
          led_out <= 1'b1;
          tmr_reg <= 32'(LONG_CYC - 1);
        end
        srfi_pkg::SRFI_FC_LONG_ON: begin
          st_reg <= srfi_pkg::SRFI_FC_LONG_OFF;
          led_out <= 1'b0;
          cnt_reg <= cnt_reg + 5'h1;
          tmr_reg <= 32'(LONG_CYC - 1);
        end
        srfi_pkg::SRFI_FC_LONG_OFF: begin
          if (cnt_reg != flashes) begin
            st_reg <= srfi_pkg::SRFI_FC_LONG_ON;
            led_out <= 1'b1;
            tmr_reg <= 32'(LONG_CYC - 1);
          end else if (dig_reg != 2'h0) begin
            dig_reg <= dig_reg - 2'h1;
            cnt_reg <= 5'h0;
            st_reg <= srfi_pkg::SRFI_FC_PAUSE;
            tmr_reg <= 32'(GAP_CYC - 1);
          end else begin
            st_reg <= srfi_pkg::SRFI_FC_SHORT_ON;
            led_out <= 1'b1;
            cnt_reg <= 5'h0;
            dig_reg <= ndig;
            tmr_reg <= 32'(SHORT_CYC - 1);
          end
        end
        default: begin
          st_reg <= srfi_pkg::SRFI_FC_IDLE;
          led_out <= 1'b0;
        end
      endcase
    end
  end
endmodule : srfi_flash_code
`default_nettype wire

// ===== design/srfi_relay.sv
// Operation
// - At power-up detect operating mode during initialisation before normal operation.
// - Blink supply LED during initialisation.
// - Supply LED steady on when ready.
// - Supply LED blinks for unknown mode or pending start action.
// - Channel-one LED lit exactly while output one high; here the LED stays lit through the output's test pulses.
// - Channel-two LED lit exactly while output two high; here the LED stays lit through the output's test pulses.
// - Supply loss longer than 20 ms is an error.
// - On supply error drive outputs low and show error on LEDs.
// - Fault holds until supply removed for 1 s and restored.
// - Coded error begins with three short flashes then a pause.
// - Each digit shown as one-second flashes, count equals value.
// - At most four digits, separated by dark gaps.
// - Coded sequence repeats while the error is present.
// - Digits 1 to 15 flash that often; zero flashes sixteen times.
// - Digit flashes last one second; sequence ends with three shorts.
// - Channel LEDs alternate on open feedback or one open channel; here only open feedback while awaiting start or one open channel in run.
// - Outputs are checked with brief test pulses while high.
// - Valid OR link enables outputs regardless of input circuit.
// - Low AND link forces outputs low.
// - Mode change during operation enters fault with coded error.
// - Monitored start needs start pressed then released.
`timescale 1ns/1ps
`default_nettype none
`include "srfi_params.svh"
module srfi_relay #(
  parameter int SUPPLY_LOSS_CYC = `SRFI_MS_TO_CYC(`SRFI_SUPPLY_LOSS_MS),
  parameter int POWER_OFF_CYC = `SRFI_MS_TO_CYC(`SRFI_POWER_OFF_MS),
  parameter int INIT_CYC = `SRFI_MS_TO_CYC(`SRFI_INIT_MS),
  parameter int BLINK_CYC = `SRFI_MS_TO_CYC(`SRFI_BLINK_HALF_MS),
  parameter int TEST_PERIOD_CYC = `SRFI_MS_TO_CYC(`SRFI_TEST_PERIOD_MS),
  parameter int TEST_PULSE_CYC = `SRFI_TEST_PULSE_US * (`SRFI_CLK_HZ / 1000000),
  parameter int SHORT_CYC = `SRFI_MS_TO_CYC(`SRFI_SHORT_FLASH_MS),
  parameter int PAUSE_CYC = `SRFI_MS_TO_CYC(`SRFI_OPEN_PAUSE_MS),
  parameter int GAP_CYC = `SRFI_MS_TO_CYC(`SRFI_DIGIT_PAUSE_MS),
  parameter int LONG_CYC = `SRFI_MS_TO_CYC(`SRFI_DIGIT_FLASH_MS)
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic supply_ok_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic mode_valid_in,
  input wire logic ch1_closed_in,
  input wire logic ch2_closed_in,
  input wire logic feedback_closed_in,
  input wire logic start_in,
  input wire logic or_link_input_in,
  input wire logic and_link_input_in,
  output logic safety_out1_out,
  output logic safety_out2_out,
  output logic power_led_out,
  output logic channel_one_indicator_out,
  output logic channel_two_indicator_out,
  output logic fault_out
);
  initial begin
    if (SUPPLY_LOSS_CYC < 1 || POWER_OFF_CYC <= SUPPLY_LOSS_CYC || INIT_CYC < 1 ||
        BLINK_CYC < 1 || TEST_PULSE_CYC < 1 || TEST_PERIOD_CYC <= TEST_PULSE_CYC) begin
      $error("srfi_relay: bad timing");
    end
    if (SHORT_CYC >= LONG_CYC || PAUSE_CYC == LONG_CYC || GAP_CYC == LONG_CYC) begin
      $error("srfi_relay: flash timings must differ from digit flash");
    end
  end
  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] sy1_reg;
  logic [NSYNC-1:0] sy2_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sy1_reg <= '0;
      sy2_reg <= '0;
    end else begin
      sy1_reg <= {supply_ok_in, mode_sel_in, mode_valid_in, ch1_closed_in, ch2_closed_in,
                  feedback_closed_in, start_in, or_link_input_in, and_link_input_in};
      sy2_reg <= sy1_reg;
    end
  end
  logic s_sup, s_mval, s_c1, s_c2, s_fb, s_start, s_or, s_and;
  logic [1:0] s_mode;
  assign {s_sup, s_mode, s_mval, s_c1, s_c2, s_fb, s_start, s_or, s_and} = sy2_reg;
  // ****************************************
  // Supply monitor and fault latch
  // ****************************************
  logic [31:0] loss_reg;
  logic sup_fault_reg;
  logic mode_fault_reg;
  logic [15:0] code_reg;
  srfi_pkg::srfi_state_t st_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      loss_reg <= 32'h0;
    end else if (s_sup) begin
      loss_reg <= 32'h0;
    end else if (loss_reg != 32'hFFFF_FFFF) begin
      loss_reg <= loss_reg + 32'h1;
    end
  end
  wire loss_err = (loss_reg >= 32'(SUPPLY_LOSS_CYC));
  wire power_cycle = s_sup && (loss_reg >= 32'(POWER_OFF_CYC));
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sup_fault_reg <= 1'b0;
    end else if (loss_err && !s_sup) begin
      sup_fault_reg <= 1'b1;
    end else if (power_cycle) begin
      sup_fault_reg <= 1'b0;
    end
  end
  // ****************************************
  // Operating state
  // ****************************************
  logic [31:0] init_reg;
  logic [1:0] mode_reg;
  logic start_seen_reg;
  logic run_ok;
  // Mode bit 1 selects monitored start; bit 0 selects start-up test
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= srfi_pkg::SRFI_INIT;
      init_reg <= 32'h0;
      mode_reg <= 2'h0;
      start_seen_reg <= 1'b0;
      mode_fault_reg <= 1'b0;
    end else if (power_cycle) begin
      st_reg <= srfi_pkg::SRFI_INIT;
      init_reg <= 32'h0;
      mode_fault_reg <= 1'b0;
      start_seen_reg <= 1'b0;
    end else begin
      case (st_reg)
        srfi_pkg::SRFI_INIT: begin
          init_reg <= init_reg + 32'h1;
          if (init_reg >= 32'(INIT_CYC - 1)) begin
            mode_reg <= s_mode;
            st_reg <= s_mval ? srfi_pkg::SRFI_WAIT_START : srfi_pkg::SRFI_BAD_MODE;
          end
        end
        srfi_pkg::SRFI_BAD_MODE: begin
          st_reg <= srfi_pkg::SRFI_BAD_MODE;
        end
        srfi_pkg::SRFI_WAIT_START: begin
          if (s_start) begin
            start_seen_reg <= 1'b1;
          end
          if (!mode_reg[1] || (start_seen_reg && !s_start)) begin
            if (!mode_reg[0] || !(s_c1 || s_c2)) begin
              st_reg <= srfi_pkg::SRFI_RUN;
            end
          end
        end
        srfi_pkg::SRFI_RUN: begin
          if (s_mode != mode_reg || !s_mval) begin
            mode_fault_reg <= 1'b1;
            st_reg <= srfi_pkg::SRFI_FAULT;
          end
        end
        srfi_pkg::SRFI_FAULT: begin
          st_reg <= srfi_pkg::SRFI_FAULT;
        end
        default: begin
          st_reg <= srfi_pkg::SRFI_INIT;
        end
      endcase
      if (sup_fault_reg) begin
        st_reg <= srfi_pkg::SRFI_FAULT;
      end
    end
  end
  wire any_fault = sup_fault_reg || mode_fault_reg;
  // Coder starts one edge after the code latches, so no frame opens on a stale code
  logic code_run_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      code_reg <= 16'h0;
      code_run_reg <= 1'b0;
    end else begin
      code_run_reg <= any_fault;
      if (sup_fault_reg) begin
        code_reg <= `SRFI_CODE_SUPPLY;
      end else if (mode_fault_reg) begin
        code_reg <= `SRFI_CODE_MODE;
      end
    end
  end
  // ****************************************
  // Output enable and test pulses
  // ****************************************
  logic [31:0] tp_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tp_reg <= 32'h0;
    end else if (tp_reg >= 32'(TEST_PERIOD_CYC - 1)) begin
      tp_reg <= 32'h0;
    end else begin
      tp_reg <= tp_reg + 32'h1;
    end
  end
  wire tp_low = (tp_reg < 32'(TEST_PULSE_CYC));
  wire local_ok = s_c1 && s_c2 && (st_reg == srfi_pkg::SRFI_RUN);
  always_comb begin
    run_ok = (local_ok || (s_or && st_reg == srfi_pkg::SRFI_RUN)) && s_and && !any_fault;
  end
  logic en_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_reg <= 1'b0;
      safety_out1_out <= 1'b0;
      safety_out2_out <= 1'b0;
    end else begin
      en_reg <= run_ok;
      safety_out1_out <= run_ok && !tp_low;
      safety_out2_out <= run_ok && !tp_low;
    end
  end
  // ****************************************
  // Indicators
  // ****************************************
  logic [31:0] bl_reg;
  logic blink_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bl_reg <= 32'h0;
      blink_reg <= 1'b0;
    end else if (bl_reg >= 32'(BLINK_CYC - 1)) begin
      bl_reg <= 32'h0;
      blink_reg <= !blink_reg;
    end else begin
      bl_reg <= bl_reg + 32'h1;
    end
  end
  logic code_led;
  srfi_flash_code #(
    .SHORT_CYC(SHORT_CYC),
    .PAUSE_CYC(PAUSE_CYC),
    .GAP_CYC(GAP_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_code (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .run_in(code_run_reg),
    .code_in(code_reg),
    .led_out(code_led)
  );
  wire alt_req = (st_reg == srfi_pkg::SRFI_WAIT_START && !s_fb) ||
                 (st_reg == srfi_pkg::SRFI_RUN && (s_c1 != s_c2));
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      power_led_out <= 1'b0;
      channel_one_indicator_out <= 1'b0;
      channel_two_indicator_out <= 1'b0;
      fault_out <= 1'b0;
    end else begin
      fault_out <= any_fault;
      power_led_out <= (st_reg == srfi_pkg::SRFI_RUN || st_reg == srfi_pkg::SRFI_FAULT) ?
                       s_sup : blink_reg;
      if (any_fault) begin
        channel_one_indicator_out <= code_led;
        channel_two_indicator_out <= 1'b0;
      end else if (alt_req) begin
        channel_one_indicator_out <= blink_reg;
        channel_two_indicator_out <= !blink_reg;
      end else begin
        channel_one_indicator_out <= en_reg;
        channel_two_indicator_out <= en_reg;
      end
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  property p_and_low;
    @(posedge sys_clk_in) disable iff (rst_in)
      !s_and |=> !safety_out1_out && !safety_out2_out;
  endproperty
  a_and_low: assert property (p_and_low) else $error("and link low but output high");
  property p_fault_low;
    @(posedge sys_clk_in) disable iff (rst_in)
      sup_fault_reg |=> !safety_out1_out && !safety_out2_out;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("output high in fault");
  property p_loss;
    @(posedge sys_clk_in) disable iff (rst_in)
      !s_sup && loss_err |=> sup_fault_reg;
  endproperty
  a_loss: assert property (p_loss) else $error("supply loss not latched");
  property p_hold;
    @(posedge sys_clk_in) disable iff (rst_in)
      sup_fault_reg && !power_cycle |=> sup_fault_reg;
  endproperty
  a_hold: assert property (p_hold) else $error("fault cleared early");
  property p_init_blink;
    @(posedge sys_clk_in) disable iff (rst_in)
      st_reg == srfi_pkg::SRFI_INIT |=> power_led_out == $past(blink_reg);
  endproperty
  a_init_blink: assert property (p_init_blink) else $error("power led not blinking");
  property p_ready;
    @(posedge sys_clk_in) disable iff (rst_in)
      st_reg == srfi_pkg::SRFI_RUN && s_sup |=> power_led_out;
  endproperty
  a_ready: assert property (p_ready) else $error("power led not steady");
  property p_ch1;
    @(posedge sys_clk_in) disable iff (rst_in)
      !any_fault && !alt_req && !tp_low ##1 !any_fault && !alt_req |=>
        channel_one_indicator_out == $past(safety_out1_out);
  endproperty
  a_ch1: assert property (p_ch1) else $error("ch1 led mismatch");
  property p_ch2;
    @(posedge sys_clk_in) disable iff (rst_in)
      !any_fault && !alt_req && !tp_low ##1 !any_fault && !alt_req |=>
        channel_two_indicator_out == $past(safety_out2_out);
  endproperty
  a_ch2: assert property (p_ch2) else $error("ch2 led mismatch");
  property p_pulse;
    @(posedge sys_clk_in) disable iff (rst_in)
      run_ok && tp_low |=> !safety_out1_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("test pulse missing");
  property p_mode_fault;
    @(posedge sys_clk_in) disable iff (rst_in)
      st_reg == srfi_pkg::SRFI_RUN && s_mode != mode_reg && !power_cycle |=> mode_fault_reg;
  endproperty
  a_mode_fault: assert property (p_mode_fault) else $error("mode change not latched");
endmodule : srfi_relay
`default_nettype wire

// ===== tb/srfi_link_unit.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************
// Upstream unit feeding the link inputs
// ********************************************
module srfi_link_unit #(
  parameter int FANOUT = 1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic or_valid_in,
  output logic and_link_out,
  output logic or_link_out
);
  // Registered like a real unit, so the links lag the command by a cycle
  // loaded output fan-out
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      and_link_out <= 1'b0;
      or_link_out <= 1'b0;
    end else begin
      and_link_out <= enable_in && (FANOUT <= 4);
      or_link_out <= or_valid_in;
    end
  end
endmodule : srfi_link_unit
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ********************************************
  // Bench signals
  // ********************************************
  localparam int SHORT = 3;
  localparam int LONG = 6;
  localparam int TPER = 50;
  localparam int TPUL = 2;
  localparam int LOSS = 20;
  localparam int POFF = 100;
  localparam int INITL = 10;
  localparam int BLNK = 4;
  localparam int PAUSE = 8;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic supply_ok = 1'b1;
  logic [1:0] mode_sel = 2'h0;
  logic mode_valid = 1'b1;
  logic ch1_closed = 1'b1;
  logic ch2_closed = 1'b1;
  logic fb_closed = 1'b1;
  logic start = 1'b0;
  logic and_cmd = 1'b1;
  logic or_cmd = 1'b0;
  wire logic and_link;
  wire logic or_link;
  wire logic out1;
  wire logic out2;
  wire logic pwr;
  wire logic led1;
  wire logic led2;
  wire logic flt;
  wire logic [7:0] obs;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  // Bit 6 flags opposite channel lamps, bit 7 a test pulse under a lit lamp
  assign obs = {led1 & ~out1, led1 ^ led2, flt, led2, led1, pwr, out2, out1};
  always #10 sys_clk_in = ~sys_clk_in;
  srfi_link_unit i_srfi_link_unit (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .enable_in(and_cmd),
    .or_valid_in(or_cmd),
    .and_link_out(and_link),
    .or_link_out(or_link)
  );
  srfi_relay #(
    .SUPPLY_LOSS_CYC(LOSS), .POWER_OFF_CYC(POFF), .INIT_CYC(INITL), .BLINK_CYC(BLNK),
    .TEST_PERIOD_CYC(TPER), .TEST_PULSE_CYC(TPUL), .SHORT_CYC(SHORT),
    .PAUSE_CYC(PAUSE), .GAP_CYC(PAUSE), .LONG_CYC(LONG)
  ) i_srfi_relay (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .supply_ok_in(supply_ok),
    .mode_sel_in(mode_sel),
    .mode_valid_in(mode_valid),
    .ch1_closed_in(ch1_closed),
    .ch2_closed_in(ch2_closed),
    .feedback_closed_in(fb_closed),
    .start_in(start),
    .or_link_input_in(or_link),
    .and_link_input_in(and_link),
    .safety_out1_out(out1),
    .safety_out2_out(out2),
    .power_led_out(pwr),
    .channel_one_indicator_out(led1),
    .channel_two_indicator_out(led2),
    .fault_out(flt)
  );
  // ********************************************
  // Tasks
  // ********************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_for(input int k, input logic v, input int lim);
    int i;
    i = 0;
    // Never look in the time step of the launching edge
    @(negedge sys_clk_in);
    while (obs[k] !== v && i < lim) begin
      @(negedge sys_clk_in);
      i++;
    end
    check(32'(obs[k]), 32'(v));
  endtask : wait_for
  task automatic count(input int k, input int len, output int hits);
    hits = 0;
    repeat (len) begin
      @(negedge sys_clk_in);
      if (obs[k] === 1'b1) hits++;
    end
  endtask : count
  // Width of the next lamp-one flash, bounded so a dead lamp cannot hang
  task automatic pulse(output int hi);
    int i;
    i = 0;
    hi = 0;
    while (led1 !== 1'b1 && i < 40) begin
      @(negedge sys_clk_in);
      i++;
    end
    while (led1 === 1'b1 && hi < 40) begin
      @(negedge sys_clk_in);
      hi++;
    end
  endtask : pulse
  task automatic check_code(input int d0, input int d1, input int nd);
    int exp_w[$];
    int hi;
    repeat (3) exp_w.push_back(SHORT);
    repeat (d0 == 0 ? 16 : d0) exp_w.push_back(LONG);
    if (nd > 1) repeat (d1 == 0 ? 16 : d1) exp_w.push_back(LONG);
    repeat (3) exp_w.push_back(SHORT);
    foreach (exp_w[j]) begin
      pulse(hi);
      check(32'(hi), 32'(exp_w[j]));
    end
  endtask : check_code
  task automatic do_reset();
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
  endtask : do_reset
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      final_report();
    end
  end
  // ********************************************
  // Scenarios
  // ********************************************
  initial begin
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(negedge sys_clk_in);
    check(32'(out1), 32'h0);
    count(2, 8, n);
    check(32'(n > 0 && n < 8), 32'h1);
    wait_for(0, 1'b1, 60);
    count(2, 20, n);
    check(32'(n), 32'h14);
    count(7, TPER, n);
    check(32'(n), 32'(TPUL));
    count(3, TPER, n);
    check(32'(n), 32'(TPER));
    count(4, TPER, n);
    check(32'(n), 32'(TPER));
    @(posedge sys_clk_in);
    and_cmd <= 1'b0;
    wait_for(0, 1'b0, 8);
    count(1, 10, n);
    check(32'(n), 32'h0);
    check(32'(led1 | led2), 32'h0);
    @(posedge sys_clk_in);
    and_cmd <= 1'b1;
    wait_for(0, 1'b1, 10);
    @(posedge sys_clk_in);
    ch1_closed <= 1'b0;
    ch2_closed <= 1'b0;
    wait_for(0, 1'b0, 8);
    @(posedge sys_clk_in);
    or_cmd <= 1'b1;
    wait_for(0, 1'b1, 10);
    wait_for(1, 1'b1, 2);
    @(posedge sys_clk_in);
    or_cmd <= 1'b0;
    ch1_closed <= 1'b1;
    ch2_closed <= 1'b1;
    wait_for(0, 1'b1, 10);
    @(posedge sys_clk_in);
    ch2_closed <= 1'b0;
    repeat (6) @(negedge sys_clk_in);
    count(6, 20, n);
    check(32'(n), 32'h14);
    count(3, 20, n);
    check(32'(n > 0 && n < 20), 32'h1);
    @(posedge sys_clk_in);
    ch2_closed <= 1'b1;
    do_reset();
    wait_for(0, 1'b1, 60);
    @(posedge sys_clk_in);
    supply_ok <= 1'b0;
    repeat (LOSS / 2) @(posedge sys_clk_in);
    supply_ok <= 1'b1;
    count(5, 30, n);
    check(32'(n), 32'h0);
    @(posedge sys_clk_in);
    supply_ok <= 1'b0;
    wait_for(5, 1'b1, 40);
    check(32'(obs[1:0]), 32'h0);
    fork
      check_code(8, 2, 2);
      begin
        repeat (10) @(posedge sys_clk_in);
        supply_ok <= 1'b1;
      end
    join
    pulse(n);
    check(32'(n), 32'(LONG));
    check(32'(flt), 32'h1);
    @(posedge sys_clk_in);
    supply_ok <= 1'b0;
    repeat (POFF + 20) @(posedge sys_clk_in);
    supply_ok <= 1'b1;
    wait_for(5, 1'b0, 10);
    wait_for(0, 1'b1, 80);
    @(posedge sys_clk_in);
    mode_sel <= 2'h1;
    wait_for(5, 1'b1, 10);
    check(32'(obs[1:0]), 32'h0);
    check_code(3, 0, 1);
    pulse(n);
    check(32'(n), 32'(LONG));
    @(posedge sys_clk_in);
    mode_valid <= 1'b0;
    do_reset();
    repeat (30) @(negedge sys_clk_in);
    count(2, 16, n);
    check(32'(n > 0 && n < 16), 32'h1);
    check(32'(out1), 32'h0);
    @(posedge sys_clk_in);
    mode_valid <= 1'b1;
    mode_sel <= 2'h2;
    fb_closed <= 1'b0;
    do_reset();
    repeat (30) @(negedge sys_clk_in);
    count(6, 16, n);
    check(32'(n), 32'h10);
    @(posedge sys_clk_in);
    fb_closed <= 1'b1;
    repeat (6) @(negedge sys_clk_in);
    count(2, 16, n);
    check(32'(n > 0 && n < 16), 32'h1);
    @(posedge sys_clk_in);
    start <= 1'b1;
    count(0, 10, n);
    check(32'(n), 32'h0);
    @(posedge sys_clk_in);
    start <= 1'b0;
    wait_for(0, 1'b1, 10);
    // Start-up test: channels must open once before the outputs come on
    @(posedge sys_clk_in);
    mode_sel <= 2'h1;
    do_reset();
    repeat (30) @(negedge sys_clk_in);
    check(32'(out1), 32'h0);
    count(2, 16, n);
    check(32'(n > 0 && n < 16), 32'h1);
    @(posedge sys_clk_in);
    ch1_closed <= 1'b0;
    ch2_closed <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    ch1_closed <= 1'b1;
    ch2_closed <= 1'b1;
    wait_for(0, 1'b1, 12);
    final_report();
  end
endmodule : tb
`default_nettype wire
